// *** common/hpsw_pkg.sv ***
/*
 * Constants, state encoding and carrier types for the hot-plug port selector.
 * Assumes a single 200 MHz clock and an asynchronous active-low reset.
 */
package hpsw_pkg;

    // Clock period of MCLK
    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_MS = 1000000;

    // Timing figures in their own units
    localparam int PRIORITY_SETTLE_PAUSE_MIN_MS = 2;
    localparam int PRIORITY_SETTLE_PAUSE_MAX_MS_X10 = 47;
    localparam int UNPLUG_SWITCH_INTERVAL_MIN_MS = 170;
    localparam int UNPLUG_SWITCH_INTERVAL_MAX_MS = 400;
    localparam int PLUG_DETECT_REPEAT_DELAY_MIN_NS = 30;
    localparam int PLUG_DETECT_REPEAT_DELAY_MAX_NS = 110;
    localparam int MIN_REPEATED_PULSE_WIDTH_NS = 100;

    // Least times round up to whole cycles
    localparam int PAUSE_CYC =
        (PRIORITY_SETTLE_PAUSE_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWITCH_CYC =
        (UNPLUG_SWITCH_INTERVAL_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REPEAT_CYC =
        (PLUG_DETECT_REPEAT_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Input synchroniser depth, counted into the repeat delay
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 32;

    // Reset values
    localparam logic SEL_RST = 1'b0;
    localparam logic LINK_EN_RST = 1'b0;
    localparam logic PLUG_OUT_RST = 1'b0;

    // Gray order along low power -> active -> pause -> force low
    typedef enum logic [1:0] {
        ST_LOWPWR = 2'h0,
        ST_ACTIVE = 2'h1,
        ST_PAUSE = 2'h3,
        ST_FORCE = 2'h2
    } hpsw_state_t;

    typedef struct packed {
        logic port_b;
        logic port_a;
    } hpsw_plug_t;

    typedef struct packed {
        logic link_en;
        logic port_b_sel;
    } hpsw_ctl_t;

endpackage

// *** logic/hpsw_top.sv ***
/*
 * Port selection and plug-detect repeating for a one-in, two-out link switch.
 * Assumes all pin inputs asynchronous to MCLK (200 MHz); analog paths outside
 * take only the enable and select outputs.
 */
module hpsw_top #(
    parameter int CNT_W = hpsw_pkg::CNT_W,
    parameter int PAUSE_CYCLES = hpsw_pkg::PAUSE_CYC,
    parameter int SWITCH_CYCLES = hpsw_pkg::SWITCH_CYC,
    parameter int DELAY_STAGES = hpsw_pkg::REPEAT_CYC - hpsw_pkg::SYNC_STAGES
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PLUG_DETECT_IN_PORT_A,
    input wire logic PLUG_DETECT_IN_PORT_B,
    input wire logic PRIORITY_SEL,
    input wire logic LINK_WAKE_EN,
    output logic PLUG_DETECT_OUT,
    output logic PORT_B_SELECTED,
    output logic LINK_ENABLE,
    output logic PORT_A_PATH_EN,
    output logic PORT_B_PATH_EN
);

    localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(PAUSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] SWITCH_LAST = CNT_W'(SWITCH_CYCLES - 1);

    hpsw_pkg::hpsw_plug_t plug_m_q;
    hpsw_pkg::hpsw_plug_t plug_s_q;
    hpsw_pkg::hpsw_plug_t plug_p_q;
    logic prio_m_q;
    logic prio_s_q;
    logic prio_p_q;
    logic wake_m_q;
    logic wake_s_q;

    hpsw_pkg::hpsw_state_t state_q;
    hpsw_pkg::hpsw_state_t state_d;
    logic sel_q;
    logic sel_d;
    logic tgt_q;
    logic tgt_d;
    logic [CNT_W-1:0] timer_q;
    logic [CNT_W-1:0] timer_d;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] low_cnt_d;
    hpsw_pkg::hpsw_ctl_t ctl_q;
    hpsw_pkg::hpsw_ctl_t ctl_d;
    logic [DELAY_STAGES-1:0] dly_q;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            plug_m_q <= '0;
            plug_s_q <= '0;
            plug_p_q <= '0;
            prio_m_q <= 1'b0;
            prio_s_q <= 1'b0;
            prio_p_q <= 1'b0;
            wake_m_q <= 1'b0;
            wake_s_q <= 1'b0;
        end else begin
            plug_m_q <= '{port_b: PLUG_DETECT_IN_PORT_B, port_a: PLUG_DETECT_IN_PORT_A};
            plug_s_q <= plug_m_q;
            plug_p_q <= plug_s_q;
            prio_m_q <= PRIORITY_SEL;
            prio_s_q <= prio_m_q;
            prio_p_q <= prio_s_q;
            wake_m_q <= LINK_WAKE_EN;
            wake_s_q <= wake_m_q;
        end
    end

    // Decoded levels; priority input high gives port B priority
    wire a_hi = plug_s_q.port_a;
    wire b_hi = plug_s_q.port_b;
    wire both_hi = a_hi & b_hi;
    wire any_hi = a_hi | b_hi;
    wire pri_b = prio_s_q;
    wire prio_chg = prio_s_q ^ prio_p_q;
    wire sel_hi = sel_q ? b_hi : a_hi;
    wire oth_hi = sel_q ? a_hi : b_hi;
    wire tgt_hi = tgt_q ? b_hi : a_hi;
    wire a_rise = a_hi & ~plug_p_q.port_a;
    wire b_rise = b_hi & ~plug_p_q.port_b;
    wire pri_rise = pri_b ? b_rise : a_rise;
    wire in_force = (state_q == hpsw_pkg::ST_FORCE);
    wire in_pause = (state_q == hpsw_pkg::ST_PAUSE);
    wire in_active = (state_q == hpsw_pkg::ST_ACTIVE);
    wire in_lowpwr = (state_q == hpsw_pkg::ST_LOWPWR);
    // While forcing low, the incoming priority port is the one watched
    wire watch_hi = in_force ? tgt_hi : sel_hi;
    wire unplug = ~watch_hi & (low_cnt_q == SWITCH_LAST);
    wire tmr_done = timer_q == (in_pause ? PAUSE_LAST : SWITCH_LAST);
    wire moving = (state_d != state_q) | (sel_d != sel_q);

    // Next-state and selection
    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        tgt_d = tgt_q;
        case (state_q)
            hpsw_pkg::ST_LOWPWR: begin
                if (any_hi) begin
                    state_d = hpsw_pkg::ST_ACTIVE;
                    sel_d = both_hi ? pri_b : b_hi;
                end
            end
            hpsw_pkg::ST_ACTIVE: begin
                if (unplug) begin
                    if (oth_hi) begin
                        sel_d = ~sel_q;
                    end else begin
                        state_d = hpsw_pkg::ST_LOWPWR;
                    end
                end else if ((sel_q != pri_b) && pri_rise) begin
                    state_d = hpsw_pkg::ST_FORCE;
                    tgt_d = pri_b;
                end else if (both_hi && prio_chg) begin
                    state_d = hpsw_pkg::ST_PAUSE;
                end
            end
            hpsw_pkg::ST_PAUSE: begin
                if (!both_hi) begin
                    state_d = hpsw_pkg::ST_ACTIVE;
                end else if (tmr_done && !prio_chg) begin
                    if (sel_q != pri_b) begin
                        state_d = hpsw_pkg::ST_FORCE;
                        tgt_d = pri_b;
                    end else begin
                        state_d = hpsw_pkg::ST_ACTIVE;
                    end
                end
            end
            hpsw_pkg::ST_FORCE: begin
                if (unplug) begin
                    // Incoming port never settled; give up the swap
                    state_d = sel_hi ? hpsw_pkg::ST_ACTIVE : hpsw_pkg::ST_LOWPWR;
                end else if (tmr_done && tgt_hi) begin
                    state_d = hpsw_pkg::ST_ACTIVE;
                    sel_d = tgt_q;
                end
            end
            default: begin
                state_d = hpsw_pkg::ST_LOWPWR;
            end
        endcase
    end

    // Pause and switch timer
    always_comb begin
        timer_d = '0;
        if (!moving && (in_pause || in_force)) begin
            if (in_force && !tgt_hi) begin
                timer_d = '0;
            end else if (in_pause && prio_chg) begin
                timer_d = '0;
            end else if (!tmr_done) begin
                timer_d = timer_q + CNT_W'(1);
            end else begin
                timer_d = timer_q;
            end
        end
    end

    assign low_cnt_d = (moving || in_lowpwr || watch_hi) ? '0 :
                       (low_cnt_q == SWITCH_LAST) ? low_cnt_q : low_cnt_q + CNT_W'(1);

    assign ctl_d = '{link_en: (state_d != hpsw_pkg::ST_LOWPWR) & wake_s_q,
                     port_b_sel: sel_d};

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= hpsw_pkg::ST_LOWPWR;
            sel_q <= hpsw_pkg::SEL_RST;
            tgt_q <= hpsw_pkg::SEL_RST;
            timer_q <= '0;
            low_cnt_q <= '0;
            ctl_q <= '{link_en: hpsw_pkg::LINK_EN_RST, port_b_sel: hpsw_pkg::SEL_RST};
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            tgt_q <= tgt_d;
            timer_q <= timer_d;
            low_cnt_q <= low_cnt_d;
            ctl_q <= ctl_d;
        end
    end

    wire out_d = (in_active | in_pause) & sel_hi;

    genvar g;
    generate
        for (g = 0; g < DELAY_STAGES; g++) begin : g_dly
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    dly_q[g] <= hpsw_pkg::PLUG_OUT_RST;
                end else begin
                    dly_q[g] <= (g == 0) ? out_d : dly_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // Pulse width survives exactly; only latency is added
    assign PLUG_DETECT_OUT = dly_q[DELAY_STAGES-1];
    assign PORT_B_SELECTED = ctl_q.port_b_sel;
    assign LINK_ENABLE = ctl_q.link_en;
    assign PORT_A_PATH_EN = ctl_q.link_en & ~ctl_q.port_b_sel;
    assign PORT_B_PATH_EN = ctl_q.link_en & ctl_q.port_b_sel;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_lowpwr_hold;
        in_lowpwr [*5];
    endsequence

    property p_lowpwr_quiet;
        s_lowpwr_hold |-> !LINK_ENABLE && !PLUG_DETECT_OUT;
    endproperty
    a_lowpwr_quiet: assert property (p_lowpwr_quiet)
        else $error("Low power state left paths or output on");

    property p_single_rise;
        in_lowpwr && (a_hi ^ b_hi) |=> in_active && (sel_q == $past(b_hi));
    endproperty
    a_single_rise: assert property (p_single_rise)
        else $error("Single rising port not selected");

    property p_both_prio;
        in_lowpwr && both_hi |=> sel_q == $past(pri_b);
    endproperty
    a_both_prio: assert property (p_both_prio)
        else $error("Priority not honoured with both ports high");

    property p_sleep_paths;
        !wake_s_q |=> !LINK_ENABLE;
    endproperty
    a_sleep_paths: assert property (p_sleep_paths)
        else $error("Paths enabled with wake pin low");

    property p_wake_paths;
        in_lowpwr && any_hi && wake_s_q |=>
            LINK_ENABLE && (PORT_B_SELECTED == $past(b_hi && (pri_b || !a_hi)));
    endproperty
    a_wake_paths: assert property (p_wake_paths)
        else $error("Wake did not enable selected path");

    property p_never_low_sel;
        (sel_d != sel_q) |-> (sel_d ? b_hi : a_hi);
    endproperty
    a_never_low_sel: assert property (p_never_low_sel)
        else $error("Switched to a port that is low");

    sequence s_follow_window;
        (in_active && $stable(sel_q)) [*5];
    endsequence

    property p_follow;
        s_follow_window |-> PLUG_DETECT_OUT == $past(sel_hi, 4);
    endproperty
    a_follow: assert property (p_follow)
        else $error("Output does not repeat the selected input");

    property p_unplug;
        in_active && unplug |=> in_lowpwr || (sel_q != $past(sel_q));
    endproperty
    a_unplug: assert property (p_unplug)
        else $error("Unplug timeout ignored");

    property p_force_entry;
        in_active && !unplug && (sel_q != pri_b) && pri_rise |=> in_force && !out_d;
    endproperty
    a_force_entry: assert property (p_force_entry)
        else $error("Priority arrival did not force output low");

    property p_restart;
        in_force && !tgt_hi && $stable(state_q) |=> timer_q == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Switch timer not restarted on glitch");

    property p_complete;
        in_force && !unplug && tmr_done && tgt_hi |=> in_active && sel_q == $past(tgt_q);
    endproperty
    a_complete: assert property (p_complete)
        else $error("Swap not completed after switch time");

    property p_prio_pause;
        in_active && !unplug && !pri_rise && both_hi && prio_chg |=> in_pause;
    endproperty
    a_prio_pause: assert property (p_prio_pause)
        else $error("Priority change not paused");

    property p_prio_kept;
        in_active && (sel_q == pri_b) && sel_hi && !(both_hi && prio_chg) |=>
            in_active && $stable(sel_q);
    endproperty
    a_prio_kept: assert property (p_prio_kept)
        else $error("Priority port selection disturbed");

    property p_pause_force;
        in_pause && both_hi && tmr_done && !prio_chg && (sel_q != pri_b) |=>
            in_force && (tgt_q != sel_q);
    endproperty
    a_pause_force: assert property (p_pause_force)
        else $error("Pause expiry did not force output low");

endmodule // hpsw_top

// *** tb/hpsw_sink_model.sv ***
/*
 * Far-side model: two sink plug-detect lines plus the priority and
 * low-power straps. Assumes the bench calls drive() once per edge.
 */
module hpsw_sink_model (
    input wire logic clk,
    output logic plug_detect_in_port_a,
    output logic plug_detect_in_port_b,
    output logic prio,
    output logic wake
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        plug_detect_in_port_a = 1'b0;
        plug_detect_in_port_b = 1'b0;
        prio = 1'b0;
        wake = 1'b0;
    end

    // Levels change only just after a rising edge
    task automatic drive(input logic a, input logic b, input logic p, input logic w);
        @(posedge clk);
        plug_detect_in_port_a <= a;
        plug_detect_in_port_b <= b;
        prio <= p;
        wake <= w;
    endtask
endmodule // hpsw_sink_model

// *** tb/tb.sv ***
/*
 * Self-checking bench for the plug-detect port selector.
 * Assumes short pause and switch counts; latencies of a few cycles.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int P = 50;
    localparam int S = 200;

    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic a_in, b_in, prio, wake;
    logic plug_out, b_sel, link_en, a_path, b_path;
    int bad_count = 0;
    int num_checks = 0;
    int cycle_cnt = 0;

    always #2.5 MCLK = ~MCLK;

    hpsw_sink_model sink_u (
        .clk(MCLK),
        .plug_detect_in_port_a(a_in),
        .plug_detect_in_port_b(b_in),
        .prio(prio),
        .wake(wake)
    );

    hpsw_top #(.PAUSE_CYCLES(P), .SWITCH_CYCLES(S)) dut_u (
        .MCLK(MCLK),
        .RST_N(RST_N),
        .PLUG_DETECT_IN_PORT_A(a_in),
        .PLUG_DETECT_IN_PORT_B(b_in),
        .PRIORITY_SEL(prio),
        .LINK_WAKE_EN(wake),
        .PLUG_DETECT_OUT(plug_out),
        .PORT_B_SELECTED(b_sel),
        .LINK_ENABLE(link_en),
        .PORT_A_PATH_EN(a_path),
        .PORT_B_PATH_EN(b_path)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge MCLK) begin
        cycle_cnt++;
        if (cycle_cnt == 10000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic go(input logic a, input logic b, input logic p, input logic w);
        sink_u.drive(a, b, p, w);
        #1;
    endtask

    task automatic expect_state(input logic sb, input logic en, input logic po);
        check("port b selected", {31'h0, sb}, {31'h0, b_sel});
        check("link enable", {31'h0, en}, {31'h0, link_en});
        check("plug out", {31'h0, po}, {31'h0, plug_out});
        check("path a", {31'h0, en & ~sb}, {31'h0, a_path});
        check("path b", {31'h0, en & sb}, {31'h0, b_path});
    endtask

    task automatic hold_check(input int n, input logic sb, input logic po);
        for (int i = 0; i < n; i++) begin
            cyc(1);
            check("held select", {31'h0, sb}, {31'h0, b_sel});
            check("held plug out", {31'h0, po}, {31'h0, plug_out});
        end
    endtask

    // Pulses the selected port low for n cycles and counts output lows
    task automatic pulse(input logic sb, input logic other, input logic p, input int n);
        int lows;
        lows = 0;
        if (sb) go(other, 1'b0, p, 1'b1);
        else go(1'b0, other, p, 1'b1);
        for (int i = 0; i < n + 15; i++) begin
            if (i == n - 1) go(sb ? other : 1'b1, sb ? 1'b1 : other, p, 1'b1);
            else cyc(1);
            if (plug_out === 1'b0) lows++;
        end
        check("pulse width", n, lows);
    endtask

    task automatic t_wake_low();
        go(1'b1, 1'b0, 1'b0, 1'b0);
        // Six pin-to-pin cycles make the 30 ns floor
        cyc(5);
        check("early plug out", 32'h0, {31'h0, plug_out});
        cyc(5);
        expect_state(1'b0, 1'b0, 1'b1);
        go(1'b0, 1'b0, 1'b0, 1'b0);
        cyc(S + 20);
        expect_state(1'b0, 1'b0, 1'b0);
    endtask

    task automatic t_single_port();
        go(1'b0, 1'b1, 1'b0, 1'b1);
        cyc(10);
        expect_state(1'b1, 1'b1, 1'b1);
        go(1'b0, 1'b1, 1'b1, 1'b1);
        go(1'b0, 1'b1, 1'b0, 1'b1);
        hold_check(P + 20, 1'b1, 1'b1);
        pulse(1'b1, 1'b0, 1'b0, 20);
        go(1'b0, 1'b0, 1'b0, 1'b1);
        cyc(S + 20);
        check("unplug link", 32'h0, {31'h0, link_en});
        check("unplug out", 32'h0, {31'h0, plug_out});
        go(1'b0, 1'b1, 1'b0, 1'b1);
        cyc(10);
        expect_state(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_priority_arrival();
        go(1'b1, 1'b1, 1'b0, 1'b1);
        cyc(10);
        expect_state(1'b1, 1'b1, 1'b0);
        cyc(90);
        go(1'b0, 1'b1, 1'b0, 1'b1);
        cyc(4);
        go(1'b1, 1'b1, 1'b0, 1'b1);
        cyc(150);
        expect_state(1'b1, 1'b1, 1'b0);
        cyc(70);
        expect_state(1'b0, 1'b1, 1'b1);
        go(1'b1, 1'b0, 1'b0, 1'b1);
        hold_check(S + 30, 1'b0, 1'b1);
        go(1'b1, 1'b1, 1'b0, 1'b1);
        hold_check(20, 1'b0, 1'b1);
    endtask

    task automatic t_priority_toggle();
        go(1'b1, 1'b1, 1'b1, 1'b1);
        go(1'b1, 1'b1, 1'b0, 1'b1);
        hold_check(P + S + 20, 1'b0, 1'b1);
        go(1'b1, 1'b1, 1'b1, 1'b1);
        hold_check(P - 10, 1'b0, 1'b1);
        cyc(25);
        expect_state(1'b0, 1'b1, 1'b0);
        cyc(S + 20);
        expect_state(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_both_high_unplug();
        pulse(1'b1, 1'b1, 1'b1, 20);
        expect_state(1'b1, 1'b1, 1'b1);
        go(1'b1, 1'b0, 1'b1, 1'b1);
        cyc(S + 20);
        expect_state(1'b0, 1'b1, 1'b1);
        go(1'b0, 1'b0, 1'b1, 1'b1);
        cyc(S + 20);
        go(1'b1, 1'b1, 1'b1, 1'b1);
        cyc(10);
        expect_state(1'b1, 1'b1, 1'b1);
    endtask

    initial begin
        repeat (5) @(posedge MCLK);
        #1;
        expect_state(1'b0, 1'b0, 1'b0);
        @(posedge MCLK);
        RST_N <= 1'b1;
        cyc(3);
        t_wake_low();
        t_single_port();
        t_priority_arrival();
        t_priority_toggle();
        t_both_high_unplug();
        stop_test();
    end
endmodule // tb
